// ==== rtl/uwb_mgmt_pkg.sv ====
// constants shared by the management register space and its memory
// assumes one clock at 25 MHz; pclk is derived from it by division
package uwb_mgmt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // address regions
  localparam logic [7:0] DYN_LAST     = 8'h1F;
  localparam logic [7:0] STATIC_FIRST = 8'h20;
  localparam logic [7:0] STATIC_LAST  = 8'h7F;
  localparam logic [7:0] VENDOR_FIRST = 8'h80;

  // dynamic registers
  localparam logic [7:0] OFF_STATE_CTRL = 8'h00;
  localparam logic [7:0] OFF_CCA_REQ    = 8'h01;
  localparam logic [7:0] OFF_STATUS     = 8'h02;

  // static capability registers
  localparam logic [7:0] OFF_REG_DOM_LO = 8'h20;
  localparam logic [7:0] OFF_REG_DOM_HI = 8'h21;
  localparam logic [7:0] OFF_RATE_LO    = 8'h22;
  localparam logic [7:0] OFF_RATE_HI    = 8'h23;
  localparam logic [7:0] OFF_CHAN_COUNT = 8'h24;

  // implemented capability bits; all others are reserved zeros
  localparam logic [15:0] REG_DOM_MASK    = 16'h00F8;
  localparam logic [15:0] RATE_MASK       = 16'h03ED;
  localparam logic [15:0] REG_DOM_DEFAULT = 16'h0008;
  localparam logic [15:0] RATE_DEFAULT    = 16'h0001;
  localparam logic [7:0]  CHAN_DEFAULT    = 8'h01;

  // register fields
  localparam int STATE_W       = 3;
  localparam int CCA_START_BIT = 0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // vendor memory
  localparam int VENDOR_AW    = 7;
  localparam int VENDOR_DEPTH = 128;

  // serial bit counter
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // channel assessment window
  localparam int CLK_PERIOD_NS     = 40;
  localparam int CCA_WINDOW_NS     = 1000;
  localparam int CCA_WINDOW_CYCLES =
    (CCA_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CCA_CNT_W = 8;

  typedef enum logic [2:0] {
    PHY_SLEEP    = 3'b000,
    PHY_STANDBY  = 3'b001,
    PHY_READY    = 3'b010,
    PHY_TRANSMIT = 3'b011,
    PHY_RECEIVE  = 3'b100
  } phy_state_e;

  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_RW    = 3'b001,
    M_ADDR  = 3'b010,
    M_WDATA = 3'b011,
    M_TURN  = 3'b100,
    M_RDATA = 3'b101
  } mgmt_state_e;

endpackage

// ==== rtl/vendor_mem_if.sv ====
// port bundle between the register space and the vendor byte memory
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface vendor_mem_if;
  import uwb_mgmt_pkg::*;
  logic                 we;
  logic [VENDOR_AW-1:0] addr;
  logic [DATA_W-1:0]    wdata;
  logic [DATA_W-1:0]    rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// ==== rtl/vendor_mem.sv ====
// byte memory behind the vendor region, registered read data
// assumes addr is held at least one clock before rdata is used
`timescale 1ns/1ps
module vendor_mem (
  // clock
  input wire logic    clk,
  // access port
  vendor_mem_if.mem   port
);
  import uwb_mgmt_pkg::*;

  logic [DATA_W-1:0] store [VENDOR_DEPTH];

  // no reset: contents are vendor scratch, left undefined
  always_ff @(posedge clk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge clk) begin
    port.rdata <= store[port.addr];
  end

endmodule

// ==== rtl/uwb_phy_mgmt_regs.sv ====
// PHY management register space: serial access, state, clock, CCA
// assumes serial pins and stop request come from the MAC, energy from radio
//
// What this block does
// - CCA request register write with bit 0 set starts assessment
// - assessment result active high, changes on pclk
// - MAC drives line for writes and headers
// - PHY drives line only for read data
// - line sampled and driven on pclk, high=one
// - reset restores defaults, pclk held idle
// - sleep: radio off, pclk stopped
// - standby: radio off, pclk unless stop request
// - ready, transmit, receive: pclk always runs
// - reserved bits stored zero, read zero
// - changeable parameters kept in real registers
// - 8-bit address selects 256 byte registers
// - dynamic, static, vendor regions by address
// - static capability values never change
// - regulatory capability bits 3 to 7 only
// - data rate capability bits 0, 2, 3 and 5 to 9
// - one byte reports channel count
// - PHY supplies pclk, signals on rising edge
// - stop request asynchronous, halts pclk in standby
`timescale 1ns/1ps
module uwb_phy_mgmt_regs
  import uwb_mgmt_pkg::*;
#(
  parameter logic [15:0] REG_DOM_CAP  = uwb_mgmt_pkg::REG_DOM_DEFAULT,
  parameter logic [15:0] RATE_CAP     = uwb_mgmt_pkg::RATE_DEFAULT,
  parameter logic [7:0]  CHAN_CAP     = uwb_mgmt_pkg::CHAN_DEFAULT,
  parameter int          CCA_CYCLES   = uwb_mgmt_pkg::CCA_WINDOW_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // interface clock to the MAC
  output logic      pclk,
  // serial management line
  input  wire logic sdata_in,
  output logic      sdata_out,
  output logic      sdata_oe_b,
  // power control from the MAC
  input  wire logic clock_stop_request,
  input  wire logic wake_request,
  // channel assessment
  input  wire logic channel_energy,
  output logic      channel_assess_result,
  // radio enables
  output logic      radio_part_on,
  output logic      radio_tx_on,
  output logic      radio_rx_on
);
  import uwb_mgmt_pkg::*;

  localparam int CCA_BOUND = 40;

  phy_state_e           phy_state;
  mgmt_state_e          mstate;
  logic                 stop_meta;
  logic                 stop_sync;
  logic                 pclk_run;
  logic                 pclk_rise;
  logic                 rd_op;
  logic [2:0]           bit_cnt;
  logic [ADDR_W-1:0]    addr_shift;
  logic [DATA_W-1:0]    data_shift;
  logic [DATA_W-1:0]    next_wdata;
  logic                 wr_strobe;
  logic [DATA_W-1:0]    read_value;
  logic                 cca_busy;
  logic                 cca_seen;
  logic [CCA_CNT_W-1:0] cca_cnt;
  logic                 cca_done_once;
  logic [15:0]          reg_dom_cap;
  logic [15:0]          rate_cap;
  logic [7:0]           chan_cap;

  vendor_mem_if vmem ();

  vendor_mem u_vendor_mem (
    .clk  (clk),
    .port (vmem.mem)
  );

  ////////////////////////////////////////////////////////////////////////
  // static capabilities: wired constants, reserved bits forced low

  assign reg_dom_cap = REG_DOM_CAP & REG_DOM_MASK;
  assign rate_cap    = RATE_CAP & RATE_MASK;
  assign chan_cap    = CHAN_CAP;

  ////////////////////////////////////////////////////////////////////////
  // stop request synchroniser, the request is asynchronous

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stop_meta <= 1'b0;
      stop_sync <= 1'b0;
    end else begin
      stop_meta <= clock_stop_request;
      stop_sync <= stop_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interface clock: clk divided by two, gated by state

  always_comb begin
    unique case (phy_state)
      PHY_SLEEP:   pclk_run = 1'b0;
      PHY_STANDBY: pclk_run = !stop_sync;
      default:     pclk_run = 1'b1;
    endcase
  end

  // a rising edge is about to be driven out on this clock
  assign pclk_rise = pclk_run && !pclk;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pclk <= 1'b0;
    end else if (pclk_run) begin
      pclk <= !pclk;
    end else begin
      pclk <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operational state and radio enables

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phy_state <= PHY_STANDBY;
    end else if (wr_strobe && addr_shift == OFF_STATE_CTRL) begin
      // unknown state codes are ignored, reserved bits dropped
      unique case (next_wdata[STATE_W-1:0])
        PHY_SLEEP:    phy_state <= PHY_SLEEP;
        PHY_STANDBY:  phy_state <= PHY_STANDBY;
        PHY_READY:    phy_state <= PHY_READY;
        PHY_TRANSMIT: phy_state <= PHY_TRANSMIT;
        PHY_RECEIVE:  phy_state <= PHY_RECEIVE;
        default:      phy_state <= phy_state;
      endcase
    end else if (phy_state == PHY_SLEEP && wake_request) begin
      phy_state <= PHY_STANDBY;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      radio_part_on <= 1'b0;
      radio_tx_on   <= 1'b0;
      radio_rx_on   <= 1'b0;
    end else begin
      radio_part_on <= (phy_state == PHY_READY);
      radio_tx_on   <= (phy_state == PHY_TRANSMIT);
      radio_rx_on   <= (phy_state == PHY_RECEIVE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial frame: start, read flag, 8 address, turnaround bit on reads, 8 data bits msb first

  assign next_wdata = {data_shift[DATA_W-2:0], sdata_in};
  assign wr_strobe  = pclk_rise && mstate == M_WDATA && bit_cnt == BIT_LAST;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mstate  <= M_IDLE;
      rd_op   <= 1'b0;
      bit_cnt <= BIT_FIRST;
    end else if (pclk_rise) begin
      unique case (mstate)
        M_IDLE: begin
          if (sdata_in) begin
            mstate <= M_RW;
          end
        end
        M_RW: begin
          rd_op   <= sdata_in;
          bit_cnt <= BIT_FIRST;
          mstate  <= M_ADDR;
        end
        M_ADDR: begin
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == BIT_LAST) begin
            mstate <= rd_op ? M_TURN : M_WDATA;
          end
        end
        M_WDATA: begin
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == BIT_LAST) begin
            mstate <= M_IDLE;
          end
        end
        M_TURN: begin
          bit_cnt <= BIT_FIRST;
          mstate  <= M_RDATA;
        end
        M_RDATA: begin
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == BIT_LAST) begin
            mstate <= M_IDLE;
          end
        end
        default: mstate <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addr_shift <= ZERO_BYTE;
    end else if (pclk_rise && mstate == M_ADDR) begin
      addr_shift <= {addr_shift[ADDR_W-2:0], sdata_in};
    end
  end

  // write data shifts in; read data loads in the turnaround bit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      data_shift <= ZERO_BYTE;
    end else if (pclk_rise) begin
      if (mstate == M_WDATA) begin
        data_shift <= next_wdata;
      end else if (mstate == M_TURN) begin
        data_shift <= read_value;
      end else if (mstate == M_RDATA) begin
        data_shift <= {data_shift[DATA_W-2:0], 1'b0};
      end
    end
  end

  // line driven only while read data goes out
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sdata_out <= 1'b0;
    end else if (pclk_rise) begin
      sdata_out <= (mstate == M_TURN) ? read_value[DATA_W-1]
                 : data_shift[DATA_W-2];
    end
  end

  assign sdata_oe_b = (mstate != M_RDATA);

  ////////////////////////////////////////////////////////////////////////
  // read decode over the three regions

  always_comb begin
    read_value = ZERO_BYTE;
    if (addr_shift >= VENDOR_FIRST) begin
      read_value = vmem.rdata;
    end else if (addr_shift >= STATIC_FIRST) begin
      unique case (addr_shift)
        OFF_REG_DOM_LO: read_value = reg_dom_cap[7:0];
        OFF_REG_DOM_HI: read_value = reg_dom_cap[15:8];
        OFF_RATE_LO:    read_value = rate_cap[7:0];
        OFF_RATE_HI:    read_value = rate_cap[15:8];
        OFF_CHAN_COUNT: read_value = chan_cap;
        default:        read_value = ZERO_BYTE;
      endcase
    end else begin
      unique case (addr_shift)
        OFF_STATE_CTRL: read_value = {5'h0_0, phy_state};
        OFF_STATUS: read_value = {5'h0_0, cca_done_once, cca_busy,
                                  channel_assess_result};
        default:        read_value = ZERO_BYTE;
      endcase
    end
  end

  // vendor region lives in memory; static region ignores writes
  assign vmem.addr  = addr_shift[VENDOR_AW-1:0];
  assign vmem.wdata = next_wdata;
  assign vmem.we    = wr_strobe && addr_shift >= VENDOR_FIRST;

  ////////////////////////////////////////////////////////////////////////
  // channel assessment: watch energy for a window, report on pclk

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cca_busy <= 1'b0;
      cca_seen <= 1'b0;
      cca_cnt  <= '0;
    end else if (wr_strobe && addr_shift == OFF_CCA_REQ
                 && next_wdata[CCA_START_BIT]) begin
      cca_busy <= 1'b1;
      cca_seen <= 1'b0;
      cca_cnt  <= CCA_CNT_W'(CCA_CYCLES - 1);
    end else if (cca_busy) begin
      cca_seen <= cca_seen | channel_energy;
      if (cca_cnt != '0) begin
        cca_cnt <= cca_cnt - CCA_CNT_W'(1);
      end else if (pclk_rise || !pclk_run) begin
        cca_busy <= 1'b0;
      end
    end
  end

  // result only moves with a pclk rising edge; a stopped clock
  // leaves the old value standing
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      channel_assess_result <= 1'b0;
      cca_done_once         <= 1'b0;
    end else if (cca_busy && cca_cnt == '0 && pclk_rise) begin
      channel_assess_result <= cca_seen | channel_energy;
      cca_done_once         <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence read_header_done;
    pclk_rise && mstate == M_TURN;
  endsequence

  sequence cca_started;
    wr_strobe && addr_shift == OFF_CCA_REQ && next_wdata[CCA_START_BIT];
  endsequence

  a_result_on_pclk: assert property (
    @(posedge clk) disable iff (!rst_b)
    $changed(channel_assess_result) |-> $past(pclk_rise))
    else $error("result changed off a pclk edge");

  a_result_first_low: assert property (
    @(posedge clk) disable iff (!rst_b)
    !cca_done_once |-> !channel_assess_result)
    else $error("result high before first assessment");

  a_cca_completes: assert property (
    @(posedge clk) disable iff (!rst_b)
    cca_started ##1 pclk_run [*8] |-> ##[1:CCA_BOUND] !cca_busy)
    else $error("assessment did not finish in time");

  a_sleep_clock_off: assert property (
    @(posedge clk) disable iff (!rst_b)
    phy_state == PHY_SLEEP ##1 phy_state == PHY_SLEEP |-> !pclk)
    else $error("pclk running in sleep");

  a_stop_halts_clock: assert property (
    @(posedge clk) disable iff (!rst_b)
    (phy_state == PHY_STANDBY && stop_sync) [*2] |-> !pclk)
    else $error("pclk running with stop request");

  a_ready_clock_runs: assert property (
    @(posedge clk) disable iff (!rst_b)
    (phy_state == PHY_READY) [*2] |-> pclk != $past(pclk))
    else $error("pclk not toggling in ready");

  a_read_drive_span: assert property (
    @(posedge clk) disable iff (!rst_b)
    read_header_done ##1 pclk_run [*8] |-> !sdata_oe_b)
    else $error("read data not driven after turnaround");

  a_write_not_driven: assert property (
    @(posedge clk) disable iff (!rst_b)
    !rd_op || mstate == M_ADDR |-> sdata_oe_b)
    else $error("line driven during mac phase");

  a_static_reads_const: assert property (
    @(posedge clk) disable iff (!rst_b)
    addr_shift == OFF_RATE_LO
      |-> read_value == (RATE_CAP[7:0] & RATE_MASK[7:0]))
    else $error("rate capability changed");

  a_radio_off_low: assert property (
    @(posedge clk) disable iff (!rst_b)
    (phy_state == PHY_STANDBY) [*2] |-> !radio_part_on && !radio_tx_on
      && !radio_rx_on)
    else $error("radio on in standby");

endmodule

// ==== bench/mac_model.sv ====
// MAC side of the serial management line, with register access tasks
// assumes pclk and the PHY line outputs come from the register space
`timescale 1ns/1ps
module mac_model (
  // phy side
  input  wire logic clk,
  input  wire logic pclk,
  input  wire logic sdata_out,
  input  wire logic sdata_oe_b,
  // line level as the phy sees it
  output logic      line
);
  logic drv;
  logic bit_v;
  logic last;

  // a released line shows the inverse of its last level, never a hold
  assign line = !sdata_oe_b ? sdata_out : drv ? bit_v : !last;
  always @(posedge clk) last <= line;

  initial begin
    drv = 1'b1;
    bit_v = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic put(input logic b);
    @(posedge pclk);
    #1 bit_v = b;
  endtask

  task automatic head(input logic rd, input logic [7:0] a);
    put(1'b1);
    put(rd);
    for (int i = 7; i >= 0; i--) put(a[i]);
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    head(1'b0, a);
    for (int i = 7; i >= 0; i--) put(d[i]);
    put(1'b0);
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    int n;
    head(1'b1, a);
    @(posedge pclk);
    #1 drv = 1'b0;
    // bit 7 leaves the phy at the next rise, one bit per rise after it
    for (int i = 7; i >= 0; i--) begin
      @(posedge pclk);
      #1 d[i] = line;
    end
    // take the line back only once the phy has let go
    n = 0;
    while (sdata_oe_b !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    bit_v = 1'b0;
    drv = 1'b1;
  endtask
endmodule

// ==== bench/uwb_phy_mgmt_register_space_bench.sv ====
// self-checking bench for the management register space
// assumes the MAC model's tasks are the only source of serial traffic
`timescale 1ns/1ps
module uwb_phy_mgmt_register_space_bench;
  import uwb_mgmt_pkg::*;
  logic       clk;
  logic       rst_b;
  logic       pclk;
  logic       line;
  logic       sdata_out;
  logic       sdata_oe_b;
  logic       clock_stop_request;
  logic       wake_request;
  logic       channel_energy;
  logic       channel_assess_result;
  logic       radio_part_on;
  logic       radio_tx_on;
  logic       radio_rx_on;
  logic       pclk_q;
  logic       res_q;
  int         n_mismatch;
  int         cmp_count;
  int         cyc;

  uwb_phy_mgmt_regs #(
    .REG_DOM_CAP (16'hFFFF),
    .RATE_CAP    (16'hFFFF),
    .CHAN_CAP    (8'h05),
    .CCA_CYCLES  (2)
  ) uwb_phy_mgmt_regs_i (
    .clk(clk), .rst_b(rst_b), .pclk(pclk), .sdata_in(line),
    .sdata_out(sdata_out), .sdata_oe_b(sdata_oe_b),
    .clock_stop_request(clock_stop_request), .wake_request(wake_request),
    .channel_energy(channel_energy),
    .channel_assess_result(channel_assess_result),
    .radio_part_on(radio_part_on), .radio_tx_on(radio_tx_on),
    .radio_rx_on(radio_rx_on)
  );

  mac_model mac_model_i (
    .clk(clk), .pclk(pclk), .sdata_out(sdata_out),
    .sdata_oe_b(sdata_oe_b), .line(line)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mac_model_i.write_reg(a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] g;
    mac_model_i.read_reg(a, g);
    chk8($sformatf("reg %h", a), e, g);
  endtask

  task automatic wait_res(input logic e);
    int n;
    n = 0;
    while (channel_assess_result !== e && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk1("result", e, channel_assess_result);
  endtask

  // running means near one rise every two clk; stopped means none
  task automatic pclk_chk(input string nm, input logic e);
    int r;
    logic p;
    r = 0;
    tick(4);
    p = pclk;
    repeat (20) begin
      tick(1);
      if (pclk && !p) r++;
      p = pclk;
    end
    chk1(nm, e, e ? r > 8 : r != 0);
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // the result may only move at a pclk rise
  always @(negedge clk) begin
    if (rst_b && channel_assess_result !== res_q && !(pclk && !pclk_q))
      chk1("result edge", res_q, channel_assess_result);
    pclk_q <= pclk;
    res_q <= channel_assess_result;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    rst_b = 1'b0;
    clock_stop_request = 1'b0;
    wake_request = 1'b0;
    channel_energy = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    tick(20);
    rst_b = 1'b1;
    chk1("result", 1'b0, channel_assess_result);
    rdchk(OFF_STATE_CTRL, 8'h01);
    rdchk(OFF_STATUS, 8'h00);
    rdchk(OFF_REG_DOM_LO, 8'hF8);
    rdchk(OFF_REG_DOM_HI, 8'h00);
    rdchk(OFF_RATE_LO, 8'hED);
    rdchk(OFF_RATE_HI, 8'h03);
    wr(OFF_CHAN_COUNT, 8'h00);
    rdchk(OFF_CHAN_COUNT, 8'h05);
    wr(8'h1F, 8'hFF);
    rdchk(8'h1F, 8'h00);
    rdchk(8'h25, 8'h00);
    wr(8'h80, 8'hA5);
    wr(8'hFF, 8'h3C);
    rdchk(8'h80, 8'hA5);
    rdchk(8'hFF, 8'h3C);
    rdchk(8'h7F, 8'h00);
    channel_energy = 1'b1;
    wr(OFF_CCA_REQ, 8'h01);
    wait_res(1'b1);
    rdchk(OFF_STATUS, 8'h05);
    rdchk(OFF_CCA_REQ, 8'h00);
    channel_energy = 1'b0;
    wr(OFF_CCA_REQ, 8'h01);
    wait_res(1'b0);
    rdchk(OFF_STATUS, 8'h04);
    channel_energy = 1'b1;
    wr(OFF_CCA_REQ, 8'h00);
    tick(8);
    rdchk(OFF_STATUS, 8'h04);
    channel_energy = 1'b0;
    for (int s = 2; s <= 4; s++) begin
      wr(OFF_STATE_CTRL, 8'(s));
      tick(4);
      chk1("part", s == 2, radio_part_on);
      chk1("tx", s == 3, radio_tx_on);
      chk1("rx", s == 4, radio_rx_on);
    end
    wr(OFF_STATE_CTRL, 8'h05);
    rdchk(OFF_STATE_CTRL, 8'h04);
    clock_stop_request = 1'b1;
    pclk_chk("pclk rx stop", 1'b1);
    wr(OFF_STATE_CTRL, 8'h01);
    pclk_chk("pclk stby stop", 1'b0);
    chk1("rx off", 1'b0, radio_rx_on);
    chk1("pclk low", 1'b0, pclk);
    clock_stop_request = 1'b0;
    pclk_chk("pclk stby", 1'b1);
    wr(OFF_STATE_CTRL, 8'h00);
    pclk_chk("pclk sleep", 1'b0);
    chk1("part off", 1'b0, radio_part_on);
    wake_request = 1'b1;
    tick(2);
    wake_request = 1'b0;
    pclk_chk("pclk wake", 1'b1);
    rdchk(OFF_STATE_CTRL, 8'h01);
    wr(OFF_STATE_CTRL, 8'h02);
    channel_energy = 1'b1;
    wr(OFF_CCA_REQ, 8'h01);
    wait_res(1'b1);
    rst_b = 1'b0;
    tick(3);
    chk1("result rst", 1'b0, channel_assess_result);
    chk1("part rst", 1'b0, radio_part_on);
    rst_b = 1'b1;
    rdchk(OFF_STATE_CTRL, 8'h01);
    rdchk(OFF_STATUS, 8'h00);
    end_sim();
  end
endmodule
